// >>> inc/adc_ctrl_pkg.sv
// Shared constants, field layouts and helpers of the converter control block.
// ***********************************************
// What this block does
// - Result is 12 bits held in two read-only byte registers.
// - Left alignment: high byte bits 11..4, low byte bits 3..0 on top.
// - Right alignment: high byte bits 11..8 low nibble, low byte bits 7..0.
// - Result bits not used by the alignment read as zero.
// - Powering the converter off keeps the stored result.
// - Start bit going 0 to 1 resets converter and clears busy.
// - Start bit going 1 to 0 with bit 5 set begins conversion and sets busy.
// - Busy flag is read-only bit 6, high only while converting.
// - Bit 5 powers converter, bit 4 picks alignment, bit 3 reads zero.
// - Channel field picks one of eight external inputs by index.
// - Internal source 000 converts the chosen external input.
// - Internal source 001 to 011 converts the converter supply.
// - Internal source 101 to 111 converts the amplifier output.
// - External and internal chosen together: only internal is converted.
// - Reference pin and bandgap chosen together: only bandgap is used.
// - A pin chosen as analog input loses its I/O function.
// - A pin chosen as analog input loses its pull-high resistor.
// - Clock field divides system clock by 1 up to 128.
// - At completion busy clears and an interrupt request is raised.
// - Reference field picks supply, pin x1..x4, bandgap x2..x4, else 0000.
// ***********************************************
package adc_ctrl_pkg;

    // ***************************
    // Register map
    // ***************************
    localparam logic [11:0] OFS_RESULT_LOW  = 12'h000;
    localparam logic [11:0] OFS_RESULT_HIGH = 12'h004;
    localparam logic [11:0] OFS_CONV_CTRL   = 12'h008;
    localparam logic [11:0] OFS_SRC_CLK     = 12'h00C;
    localparam logic [11:0] OFS_REF_AMP     = 12'h010;
    localparam logic [7:0]  CTRL_RESET      = 8'h00;

    // ***************************
    // Field positions
    // ***************************
    localparam int BIT_START     = 7;
    localparam int BIT_BUSY      = 6;
    localparam int BIT_POWER     = 5;
    localparam int BIT_ALIGN     = 4;
    localparam int BIT_AMP       = 7;
    localparam int BIT_BANDGAP   = 6;
    localparam int INS_LSB       = 5;
    localparam int RESULT_W      = 12;

    // ***************************
    // Codes and timing
    // ***************************
    localparam logic [2:0]  INS_EXTERNAL = 3'h0;
    localparam logic [2:0]  INS_SUPPLY_HI = 3'h3;
    localparam logic [2:0]  INS_AMP_LO    = 3'h5;
    localparam logic [1:0]  ROUTE_EXT    = 2'h0;
    localparam logic [1:0]  ROUTE_SUPPLY = 2'h1;
    localparam logic [1:0]  ROUTE_AMP    = 2'h2;
    localparam logic [3:0]  REF_SUPPLY   = 4'h0;
    localparam logic [3:0]  REF_PIN_HI   = 4'h4;
    localparam logic [3:0]  REF_BG_LO    = 4'hA;
    localparam logic [3:0]  REF_BG_HI    = 4'hC;
    localparam logic [3:0]  SAMPLE_TICKS = 4'h4;
    localparam logic [11:0] SAR_TOP_BIT  = 12'h800;

    // Formats one result byte for the current alignment.
    function automatic logic [7:0] alignByte(
        input logic [11:0] d,
        input logic        right,
        input logic        high
    );
        if (high) begin
            alignByte = right ? {4'h0, d[11:8]} : d[11:4];
        end else begin
            alignByte = right ? d[7:0] : {d[3:0], 4'h0};
        end
    endfunction : alignByte

endpackage : adc_ctrl_pkg

// >>> hdl/adc_clock_divider.sv
// Converter clock divider producing a one-cycle tick enable.
`timescale 1ns/1ps
module adc_clock_divider (
    // Clock and reset.
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    // Control.
    input  wire logic [2:0] divSelect,
    input  wire logic       restart,
    // Converter clock enable.
    output logic            tick
);

    logic [6:0] count;
    wire  logic [6:0] mask;

    assign mask = 7'((8'h01 << divSelect) - 8'h01);
    assign tick = (count & mask) == mask;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            count <= 7'h00;
        end else begin
            count <= restart ? 7'h00 : count + 7'h01;
        end
    end

endmodule : adc_clock_divider

// >>> hdl/adc_sar_sequencer.sv
// Successive-approximation sequencer: sample phase, twelve bit trials.
`timescale 1ns/1ps
module adc_sar_sequencer (
    // Clock and reset.
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    // Control.
    input  wire logic        tick,
    input  wire logic        abort,
    input  wire logic        go,
    input  wire logic        cmpHigh,
    // Status and data.
    output logic             busy,
    output logic             done,
    output logic             sampling,
    output logic [11:0]      dacCode,
    output logic [11:0]      result
);

    typedef enum logic [1:0] {IDLE, SAMPLE, CONVERT, FINISH} seqState_e;

    seqState_e   state;
    logic [3:0]  sampleCount;
    logic [11:0] trialMask;
    wire  logic [11:0] kept;

    // A trial bit stays only if the input is not below the DAC level.
    assign kept = cmpHigh ? dacCode : (dacCode & ~trialMask);

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state       <= IDLE;
            busy        <= 1'b0;
            done        <= 1'b0;
            sampling    <= 1'b0;
            sampleCount <= 4'h0;
            trialMask   <= 12'h000;
            dacCode     <= 12'h000;
            result      <= 12'h000;
        end else if (abort) begin
            // Result is left alone so that a power-down keeps it.
            state    <= IDLE;
            busy     <= 1'b0;
            done     <= 1'b0;
            sampling <= 1'b0;
        end else if (go) begin
            state       <= SAMPLE;
            busy        <= 1'b1;
            done        <= 1'b0;
            sampling    <= 1'b1;
            sampleCount <= 4'h0;
        end else begin
            done <= 1'b0;
            case (state)
                IDLE: begin
                    sampling <= 1'b0;
                end
                SAMPLE: begin
                    if (tick) begin
                        sampleCount <= sampleCount + 4'h1;
                        if (sampleCount ==
                            adc_ctrl_pkg::SAMPLE_TICKS - 4'h1) begin
                            state     <= CONVERT;
                            sampling  <= 1'b0;
                            trialMask <= adc_ctrl_pkg::SAR_TOP_BIT;
                            dacCode   <= adc_ctrl_pkg::SAR_TOP_BIT;
                        end
                    end
                end
                CONVERT: begin
                    if (tick) begin
                        if (trialMask[0]) begin
                            result <= kept;
                            state  <= FINISH;
                        end else begin
                            dacCode   <= kept | (trialMask >> 1);
                            trialMask <= trialMask >> 1;
                        end
                    end
                end
                FINISH: begin
                    busy  <= 1'b0;
                    done  <= 1'b1;
                    state <= IDLE;
                end
                default: begin
                    state <= IDLE;
                end
            endcase
        end
    end

endmodule : adc_sar_sequencer

// >>> hdl/adc_control_registers.sv
// Converter control top: APB registers, start logic and analog routing.
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ps
module adc_control_registers (
    // Clock and reset.
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    // APB slave.
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Comparator from the analog core.
    input  wire logic        cmpHigh,
    // Pin-sharing selection from the port logic.
    input  wire logic [7:0]  analogPinSel,
    // Converter core controls.
    output logic             converterPowerEnable,
    output logic             sampleHold,
    output logic      [11:0] dacCode,
    // Input routing.
    output logic      [1:0]  inputRoute,
    output logic      [1:0]  inputScale,
    output logic             externalInputConnect,
    output logic      [2:0]  channelSelect,
    // Reference routing.
    output logic      [3:0]  refSelect,
    output logic             refFromPin,
    output logic             refFromBandgap,
    output logic             ampBandgapInput,
    output logic             amplifierEnable,
    output logic             bandgapBufferEnable,
    // Completion event to the interrupt controller.
    output logic             conversionDoneIrq,
    // Pin function release.
    output logic      [7:0]  pinIoRelease,
    output logic      [7:0]  pullUpRelease
);

    // ***************************
    // Register fields
    // ***************************
    logic       startBit;
    logic       resultAlignment;
    logic [2:0] externalChannelField;
    logic [2:0] internalSourceField;
    logic [2:0] converterClockDivider;
    logic [3:0] referenceSelectField;

    // ***************************
    // Sequencer wires
    // ***************************
    wire logic        convTick;
    wire logic        conversionBusyFlag;
    wire logic        seqDone;
    wire logic        seqSampling;
    wire logic [11:0] seqDac;
    wire logic [11:0] resultData;

    // ***************************
    // APB decode
    // ***************************
    wire logic       apbSetup;
    wire logic       apbAccess;
    wire logic       wrByte;
    wire logic       hitLow;
    wire logic       hitHigh;
    wire logic       hitCtrl;
    wire logic       hitSrc;
    wire logic       hitRef;
    wire logic       hitAny;
    wire logic       wrCtrl;
    wire logic       wrSrc;
    wire logic       wrRef;
    wire logic [7:0] wByte;

    assign apbSetup  = psel & ~penable;
    assign apbAccess = psel & penable & pready;
    assign wrByte    = apbAccess & pwrite & pstrb[0];
    assign wByte     = pwdata[7:0];

    assign hitLow  = paddr == adc_ctrl_pkg::OFS_RESULT_LOW;
    assign hitHigh = paddr == adc_ctrl_pkg::OFS_RESULT_HIGH;
    assign hitCtrl = paddr == adc_ctrl_pkg::OFS_CONV_CTRL;
    assign hitSrc  = paddr == adc_ctrl_pkg::OFS_SRC_CLK;
    assign hitRef  = paddr == adc_ctrl_pkg::OFS_REF_AMP;
    assign hitAny  = hitLow | hitHigh | hitCtrl | hitSrc | hitRef;

    // Writes to the result registers are dropped without error.
    assign wrCtrl = wrByte & hitCtrl;
    assign wrSrc  = wrByte & hitSrc;
    assign wrRef  = wrByte & hitRef;

    // ***************************
    // Start bit edges
    // ***************************
    wire logic startRise;
    wire logic startFall;
    wire logic powerNext;
    wire logic seqAbort;
    wire logic seqGo;

    assign startRise = wrCtrl & ~startBit & wByte[adc_ctrl_pkg::BIT_START];
    assign startFall = wrCtrl & startBit & ~wByte[adc_ctrl_pkg::BIT_START];
    assign powerNext = wrCtrl ? wByte[adc_ctrl_pkg::BIT_POWER]
                              : converterPowerEnable;

    // A powered-down converter cannot run, so power-off also aborts.
    assign seqAbort = startRise | ~powerNext;
    assign seqGo    = startFall & powerNext;

    // ***************************
    // Read data
    // ***************************
    wire logic [7:0] rdCtrl;
    wire logic [7:0] rdSrc;
    wire logic [7:0] rdRef;
    wire logic [7:0] rdLow;
    wire logic [7:0] rdHigh;
    wire logic [7:0] rdByte;

    // Bit 3 of the first control register is unimplemented.
    assign rdCtrl = {startBit, conversionBusyFlag, converterPowerEnable,
                     resultAlignment, 1'b0,
                     externalChannelField};
    assign rdSrc  = {internalSourceField, 2'b00, converterClockDivider};
    assign rdRef  = {amplifierEnable, bandgapBufferEnable, 2'b00,
                     referenceSelectField};

    assign rdLow  = adc_ctrl_pkg::alignByte(resultData, resultAlignment,
                                            1'b0);
    assign rdHigh = adc_ctrl_pkg::alignByte(resultData, resultAlignment,
                                            1'b1);

    assign rdByte = hitLow  ? rdLow  :
                    hitHigh ? rdHigh :
                    hitCtrl ? rdCtrl :
                    hitSrc  ? rdSrc  :
                    hitRef  ? rdRef  : 8'h00;

    // ***************************
    // APB answer
    // ***************************
    // Data and error are sampled in the setup cycle, so every transfer
    // completes with no wait state; busy may change by then but is
    // still one cycle fresh.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= apbSetup;
            pslverr <= apbSetup & ~hitAny;
            prdata  <= (apbSetup & ~pwrite) ? {24'h00_0000, rdByte}
                                            : 32'h0000_0000;
        end
    end

    // ***************************
    // Conversion control register
    // ***************************
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            startBit             <= 1'b0;
            converterPowerEnable <= 1'b0;
            resultAlignment      <= 1'b0;
            externalChannelField <= 3'h0;
        end else if (wrCtrl) begin
            startBit             <= wByte[adc_ctrl_pkg::BIT_START];
            converterPowerEnable <= wByte[adc_ctrl_pkg::BIT_POWER];
            resultAlignment      <= wByte[adc_ctrl_pkg::BIT_ALIGN];
            externalChannelField <= wByte[2:0];
        end
    end

    // ***************************
    // Source and clock register
    // ***************************
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            internalSourceField   <= 3'h0;
            converterClockDivider <= 3'h0;
        end else if (wrSrc) begin
            internalSourceField   <= wByte[7:adc_ctrl_pkg::INS_LSB];
            converterClockDivider <= wByte[2:0];
        end
    end

    // ***************************
    // Reference and amplifier register
    // ***************************
    // The amplifier is never forced on here: software owns that bit.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            amplifierEnable      <= 1'b0;
            bandgapBufferEnable  <= 1'b0;
            referenceSelectField <= 4'h0;
        end else if (wrRef) begin
            amplifierEnable      <= wByte[adc_ctrl_pkg::BIT_AMP];
            bandgapBufferEnable  <= wByte[adc_ctrl_pkg::BIT_BANDGAP];
            referenceSelectField <= wByte[3:0];
        end
    end

    // ***************************
    // Input source decode
    // ***************************
    wire logic       srcSupply;
    wire logic       srcAmp;
    wire logic [1:0] nextRoute;

    assign srcSupply = (internalSourceField != adc_ctrl_pkg::INS_EXTERNAL)
                     & (internalSourceField <= adc_ctrl_pkg::INS_SUPPLY_HI);
    assign srcAmp    = internalSourceField >= adc_ctrl_pkg::INS_AMP_LO;

    // Internal sources win over the external channel; 100 acts as 000.
    assign nextRoute = srcSupply ? adc_ctrl_pkg::ROUTE_SUPPLY :
                       srcAmp    ? adc_ctrl_pkg::ROUTE_AMP    :
                                   adc_ctrl_pkg::ROUTE_EXT;

    // ***************************
    // Reference decode
    // ***************************
    wire logic       refPinCode;
    wire logic       refBgCode;
    wire logic [3:0] nextRef;

    assign refPinCode = (referenceSelectField != adc_ctrl_pkg::REF_SUPPLY)
                      & (referenceSelectField <= adc_ctrl_pkg::REF_PIN_HI);
    assign refBgCode  = (referenceSelectField >= adc_ctrl_pkg::REF_BG_LO)
                      & (referenceSelectField <= adc_ctrl_pkg::REF_BG_HI);

    // A bandgap code never also routes the pin, so bandgap alone is used.
    assign nextRef = (refPinCode | refBgCode) ? referenceSelectField
                                              : adc_ctrl_pkg::REF_SUPPLY;

    // ***************************
    // Routing outputs
    // ***************************
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            inputRoute           <= adc_ctrl_pkg::ROUTE_EXT;
            inputScale           <= 2'h0;
            // Source 000 routes the external pin, so connect starts high.
            externalInputConnect <= 1'b1;
            channelSelect        <= 3'h0;
        end else begin
            inputRoute           <= nextRoute;
            inputScale           <= internalSourceField[1:0];
            externalInputConnect <= (nextRoute ==
                                     adc_ctrl_pkg::ROUTE_EXT);
            channelSelect        <= externalChannelField;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            refSelect       <= adc_ctrl_pkg::REF_SUPPLY;
            refFromPin      <= 1'b0;
            refFromBandgap  <= 1'b0;
            ampBandgapInput <= 1'b0;
        end else begin
            refSelect       <= nextRef;
            refFromPin      <= refPinCode;
            refFromBandgap  <= refBgCode;
            ampBandgapInput <= refBgCode;
        end
    end

    // ***************************
    // Pins and completion event
    // ***************************
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pinIoRelease      <= 8'h00;
            pullUpRelease     <= 8'h00;
            conversionDoneIrq <= 1'b0;
        end else begin
            pinIoRelease      <= analogPinSel;
            pullUpRelease     <= analogPinSel;
            conversionDoneIrq <= seqDone;
        end
    end

    // ***************************
    // Converter core
    // ***************************
    // The divider restarts with each conversion so that its length in
    // system clocks is fixed for a given divider setting.
    adc_clock_divider clockDivider (
        .core_clk  (core_clk),
        .rst_b     (rst_b),
        .divSelect (converterClockDivider),
        .restart   (seqGo | seqAbort),
        .tick      (convTick)
    );

    adc_sar_sequencer sequencer (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .tick     (convTick),
        .abort    (seqAbort),
        .go       (seqGo),
        .cmpHigh  (cmpHigh),
        .busy     (conversionBusyFlag),
        .done     (seqDone),
        .sampling (seqSampling),
        .dacCode  (seqDac),
        .result   (resultData)
    );

    // Sample and DAC lines pass out of the sequencer's own flip-flops.
    assign sampleHold = seqSampling;
    assign dacCode    = seqDac;

endmodule : adc_control_registers

// >>> verification/adc_control_registers_props.sv
// Port checker of the converter control block.
`timescale 1ns/1ps
module adc_control_registers_props (
    // Clock and reset.
    input wire logic        core_clk,
    input wire logic        rst_b,
    // Register bus.
    input wire logic [11:0] paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    // Routing and events.
    input wire logic [7:0]  analogPinSel,
    input wire logic [7:0]  pinIoRelease,
    input wire logic [7:0]  pullUpRelease,
    input wire logic [1:0]  inputRoute,
    input wire logic        externalInputConnect,
    input wire logic [3:0]  refSelect,
    input wire logic        refFromPin,
    input wire logic        refFromBandgap,
    input wire logic        ampBandgapInput,
    input wire logic        conversionDoneIrq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // ***************************
    // Properties
    // ***************************
    sequence s_irqRise; $rose(conversionDoneIrq); endsequence
    sequence s_irqQuiet; !conversionDoneIrq [*4]; endsequence
    property p_irqPulse; s_irqRise |=> s_irqQuiet; endproperty
    property p_pinRel; pinIoRelease == $past(analogPinSel); endproperty
    property p_pullRel; pullUpRelease == $past(analogPinSel); endproperty
    property p_extConn;
        externalInputConnect == (inputRoute == adc_ctrl_pkg::ROUTE_EXT);
    endproperty
    property p_route; inputRoute != 2'h3; endproperty
    property p_refExcl; !(refFromPin && refFromBandgap); endproperty
    property p_refCode;
        refSelect <= adc_ctrl_pkg::REF_PIN_HI ||
        (refSelect >= adc_ctrl_pkg::REF_BG_LO &&
         refSelect <= adc_ctrl_pkg::REF_BG_HI);
    endproperty
    property p_ampBg; ampBandgapInput == refFromBandgap; endproperty
    property p_ctrlRd;
        psel && penable && pready && !pwrite &&
        paddr == adc_ctrl_pkg::OFS_CONV_CTRL |->
        prdata[3] == 1'b0 && prdata[31:8] == 24'h0;
    endproperty
    a_irqPulse: assert property (p_irqPulse)
        else $error("completion pulse too long");
    a_pinRel: assert property (p_pinRel)
        else $error("pin release lags wrongly");
    a_pullRel: assert property (p_pullRel)
        else $error("pull release lags wrongly");
    a_extConn: assert property (p_extConn)
        else $error("external connect disagrees with route");
    a_route: assert property (p_route)
        else $error("illegal route code");
    a_refExcl: assert property (p_refExcl)
        else $error("pin and bandgap reference together");
    a_refCode: assert property (p_refCode)
        else $error("illegal reference code");
    a_ampBg: assert property (p_ampBg)
        else $error("amplifier input disagrees with reference");
    a_ctrlRd: assert property (p_ctrlRd)
        else $error("control read has stray bits");
endmodule : adc_control_registers_props

bind adc_control_registers adc_control_registers_props props_inst (
    .core_clk, .rst_b, .paddr, .psel, .penable, .pwrite, .prdata, .pready,
    .analogPinSel, .pinIoRelease, .pullUpRelease, .inputRoute,
    .externalInputConnect, .refSelect, .refFromPin, .refFromBandgap,
    .ampBandgapInput, .conversionDoneIrq
);

// >>> verification/tb_adc_control_registers.sv
// Self-checking bench of the converter control block.
`timescale 1ns/1ps
module tb_adc_control_registers;
    logic        core_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'hF;
    logic        cmpHigh = 1'b0;
    logic [7:0]  analogPinSel = 8'h00;
    logic [11:0] target = 12'hA5C;
    logic [31:0] prdata, rd;
    logic [11:0] dacCode;
    logic [1:0]  inputRoute, inputScale;
    logic [2:0]  channelSelect;
    logic [3:0]  refSelect;
    logic [7:0]  pinIoRelease, pullUpRelease;
    logic        pready, pslverr, lastErr, sampleHold, converterPowerEnable;
    logic        externalInputConnect, refFromPin, refFromBandgap;
    logic        ampBandgapInput, amplifierEnable, bandgapBufferEnable;
    logic        conversionDoneIrq;
    int          err_total = 0, check_count = 0, irqs = 0, i;
    localparam logic [11:0] CC = adc_ctrl_pkg::OFS_CONV_CTRL;
    localparam logic [11:0] RL = adc_ctrl_pkg::OFS_RESULT_LOW;
    localparam logic [11:0] RH = adc_ctrl_pkg::OFS_RESULT_HIGH;
    localparam logic [11:0] SC = adc_ctrl_pkg::OFS_SRC_CLK;
    localparam logic [11:0] RA = adc_ctrl_pkg::OFS_REF_AMP;

    always #2.5 core_clk = ~core_clk;
    // The comparator model keeps a trial bit while the code is at or below.
    always @(posedge core_clk) cmpHigh <= (dacCode <= target);
    always @(posedge core_clk) if (conversionDoneIrq === 1'b1) irqs <= irqs + 1;

    adc_control_registers adc_control_registers_inst (
        .core_clk, .rst_b, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .cmpHigh, .analogPinSel,
        .converterPowerEnable, .sampleHold, .dacCode, .inputRoute,
        .inputScale, .externalInputConnect, .channelSelect, .refSelect,
        .refFromPin, .refFromBandgap, .ampBandgapInput, .amplifierEnable,
        .bandgapBufferEnable, .conversionDoneIrq, .pinIoRelease,
        .pullUpRelease
    );

    // ***************************
    // Bus tasks
    // ***************************
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rd = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr
    task automatic rdc(input string nm, input logic [11:0] a,
                       input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask : rdc
    task automatic end_sim;
        $display("errors %0d checks %0d", err_total, check_count);
        if (err_total == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_sim

    initial begin
        #100000;
        err_total++;
        end_sim();
    end

    // ***************************
    // Tests
    // ***************************
    initial begin
        repeat (4) @(posedge core_clk);
        rst_b <= 1'b1;
        for (i = 0; i < 5; i++) rdc("reset", 12'(i * 4), 32'h0);
        rdc("unmapped", 12'h014, 32'h0);
        chk("slverr", 32'h1, 32'(lastErr));
        wr(SC, 32'hFF);
        rdc("source reg", SC, 32'hE7);
        wr(RA, 32'hFF);
        rdc("ref reg", RA, 32'hCF);
        chk("amp", 32'h3, {amplifierEnable, bandgapBufferEnable});
        wr(CC, 32'h7F);
        rdc("ctrl reg", CC, 32'h37);
        chk("channel", 32'h7, 32'(channelSelect));
        for (i = 0; i < 8; i++) begin
            wr(SC, 32'(i << 5));
            repeat (2) @(posedge core_clk);
            chk("route", (i % 4 == 0) ? 0 : (i < 4 ? 1 : 2),
                inputRoute);
            chk("ext", 32'(i % 4 == 0),
                32'(externalInputConnect));
            chk("scale", i % 4, 32'(inputScale));
        end
        for (i = 0; i < 16; i++) begin
            wr(RA, 32'(i));
            repeat (2) @(posedge core_clk);
            chk("ref", (i <= 4 || (i >= 10 && i <= 12)) ? i : 0,
                refSelect);
            chk("pin", 32'(i >= 1 && i <= 4), 32'(refFromPin));
            chk("bg", 32'(i >= 10 && i <= 12), 32'(refFromBandgap));
        end
        analogPinSel <= 8'h5A;
        repeat (3) @(posedge core_clk);
        chk("pins", 32'h5A5A, {pinIoRelease, pullUpRelease});
        wr(SC, 32'h02);
        wr(CC, 32'hA0);
        wr(CC, 32'h20);
        rdc("busy", CC, 32'h60);
        chk("sample", 32'h1, 32'(sampleHold));
        for (i = 0; i < 100 && rd[6] !== 1'b0; i++) xfer(1'b0, CC, 32'h0);
        chk("done", 32'h20, rd);
        repeat (2) @(posedge core_clk);
        chk("irq", 32'h1, 32'(irqs));
        rdc("hi left", RH, 32'hA5);
        rdc("lo left", RL, 32'hC0);
        wr(CC, 32'h30);
        rdc("hi right", RH, 32'h0A);
        rdc("lo right", RL, 32'h5C);
        wr(RL, 32'hFF);
        rdc("lo ro", RL, 32'h5C);
        target <= 12'h123;
        wr(CC, 32'hB0);
        wr(CC, 32'h30);
        wr(CC, 32'hB0);
        rdc("abort", CC, 32'hB0);
        wr(CC, 32'h10);
        rdc("off", CC, 32'h10);
        chk("power", 32'h0, 32'(converterPowerEnable));
        rdc("kept", RL, 32'h5C);
        end_sim();
    end
endmodule : tb_adc_control_registers
